// ==== logic/amf_port.sv ====
// Device end: APB-programmed multidrop serial port with flow control
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
module amf_port #(
    parameter int DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic dma_tx_req,
    output logic dma_rx_req,
    amf_link_if.dev link
);
    localparam int AW = $clog2(DEPTH);

    //======================================================================
    // Registers and state
    logic [31:0] ctrl, cfg, mask;
    logic [amf_pkg::ST_W-1:0] stat;
    logic [15:0] div;
    logic [9:0] tq [DEPTH];
    logic [10:0] rq [DEPTH];
    logic [AW-1:0] tq_wp, tq_rp, rq_wp, rq_rp;
    logic [AW:0] tq_cnt, rq_cnt;
    amf_pkg::amf_tx_st_t tx_st;
    amf_pkg::amf_rx_st_t rx_st;
    logic [15:0] tx_bc, rx_bc;
    logic [9:0] tx_idx, tx_nlow, tx_total;
    logic [15:0] tx_sh;
    logic tx_brk, txd, rts_n;
    logic [11:0] rx_sh;
    logic [3:0] rx_idx;
    logic rx_q1, rx_q2, rx_q3, cts_q1, cts_q2, rx_fin, node_sel;

    //======================================================================
    // Decoding
    wire [1:0] len = ctrl[amf_pkg::CTRL_LEN +: 2];
    wire [1:0] par = ctrl[amf_pkg::CTRL_PAR +: 2];
    wire [1:0] stop = ctrl[amf_pkg::CTRL_STOP +: 2];
    wire multidrop_bus_mode = ctrl[amf_pkg::CTRL_MDB];
    wire afc = ctrl[amf_pkg::CTRL_AFC];
    wire [7:0] gap = cfg[amf_pkg::CFG_GAP +: 8];
    wire [7:0] brk_len = cfg[amf_pkg::CFG_BRK +: 8];
    wire [3:0] rts_lvl = cfg[amf_pkg::CFG_RTS +: 4];
    wire [7:0] node = cfg[amf_pkg::CFG_NODE +: 8];
    // Zero divider would stall the bit timers
    wire [15:0] bit_cyc = (div == 16'h0) ? 16'h1 : div;
    wire setup = psel && !penable;
    wire acc = psel && penable;
    wire sel_ctrl = paddr == amf_pkg::OFF_CTRL;
    wire sel_div = paddr == amf_pkg::OFF_DIV;
    wire sel_cfg = paddr == amf_pkg::OFF_CFG;
    wire sel_txd = paddr == amf_pkg::OFF_TXD;
    wire sel_rxd = paddr == amf_pkg::OFF_RXD;
    wire sel_stat = paddr == amf_pkg::OFF_STAT;
    wire sel_mask = paddr == amf_pkg::OFF_MASK;
    wire mapped = sel_ctrl | sel_div | sel_cfg | sel_txd | sel_rxd | sel_stat | sel_mask;
    wire wr = acc && pwrite && mapped;
    wire tq_full = tq_cnt == (AW+1)'(DEPTH);
    wire rq_full = rq_cnt == (AW+1)'(DEPTH);
    wire rq_empty = rq_cnt == '0;
    wire tq_push = wr && sel_txd && !tq_full;
    wire rq_pop = acc && !pwrite && sel_rxd && !rq_empty;

    //======================================================================
    // Transmit path
    wire [9:0] tq_head = tq[tq_rp];
    wire [3:0] nlow = amf_pkg::amf_nlow(len, par, multidrop_bus_mode);
    wire [9:0] go_low = tq_head[9] ? {2'h0, brk_len} : {6'h0, nlow};
    wire [9:0] go_total = go_low + {8'h0, stop} + 10'h1 + {2'h0, gap};
    wire tx_tick = tx_bc == 16'h1;
    wire tx_go = tx_st == amf_pkg::TXS_IDLE && tq_cnt != '0 && (!afc || !cts_q2);
    wire tx_end = tx_st == amf_pkg::TXS_RUN && tx_tick && tx_idx == tx_total - 10'h1;
    wire low_cell = tx_st == amf_pkg::TXS_RUN && tx_idx < tx_nlow;
    // Break cells drive low; data cells send the frame, everything else idles high
    wire next_txd = !low_cell || (!tx_brk && tx_sh[tx_idx[3:0]]);

    //======================================================================
    // Receive path
    wire [10:0] rx_word = amf_pkg::amf_unpack(len, par, multidrop_bus_mode, rx_sh);
    wire rx_tick = rx_bc == 16'h1;
    wire rx_done = rx_st == amf_pkg::RXS_BITS && rx_tick && rx_idx == nlow;
    wire rx_hit = rx_word[7:0] == node;
    // Frames for other nodes are dropped before any event can fire
    wire rx_take = !multidrop_bus_mode || (rx_word[8] ? rx_hit : node_sel);
    wire rq_push = rx_fin && rx_take && !rq_full;
    wire ovr = rx_fin && rx_take && rq_full;
    wire [amf_pkg::ST_W-1:0] ev = {rx_fin && rx_take && rx_word[10], ovr,
        rx_fin && rx_take && rx_word[9], tx_end, rq_push};
    wire [amf_pkg::ST_W-1:0] w1c = (wr && sel_stat) ? pwdata[amf_pkg::ST_W-1:0] : '0;
    wire [31:0] st_word = {8'h0, 8'(tq_cnt), 8'(rq_cnt), 3'h0, stat};
    wire [31:0] rxd_word = {rq_empty, 20'h0, rq[rq_rp]};
    wire [31:0] rd_mux = sel_ctrl ? ctrl : sel_div ? {16'h0, div} : sel_cfg ? cfg :
        sel_rxd ? rxd_word : sel_stat ? st_word : sel_mask ? mask : 32'h0;

    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign irq = |(stat & mask[amf_pkg::ST_W-1:0]);
    assign dma_tx_req = ctrl[amf_pkg::CTRL_DTX] && !tq_full;
    assign dma_rx_req = ctrl[amf_pkg::CTRL_DRX] && !rq_empty;
    assign link.to_rem = txd;
    assign link.rts_n = rts_n;

    //======================================================================
    // Register file
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= amf_pkg::CTRL_RST;
            div <= amf_pkg::DIV_RST;
            cfg <= amf_pkg::CFG_RST;
            mask <= 32'h0;
            stat <= '0;
            prdata <= 32'h0;
        end
        else
        begin
            if (wr && sel_ctrl)
                ctrl <= pwdata;
            if (wr && sel_div)
                div <= pwdata[15:0];
            if (wr && sel_cfg)
                cfg <= pwdata;
            if (wr && sel_mask)
                mask <= pwdata;
            // A new event outranks a clear in the same cycle
            stat <= (stat & ~w1c) | ev;
            if (setup)
                prdata <= rd_mux;
        end
    end

    //======================================================================
    // Queues
    always_ff @(posedge pclk)
    begin
        if (tq_push)
            tq[tq_wp] <= {pwdata[amf_pkg::TXD_BRK], pwdata[8:0]};
        if (rq_push)
            rq[rq_wp] <= rx_word;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tq_wp <= '0;
            tq_rp <= '0;
            tq_cnt <= '0;
            rq_wp <= '0;
            rq_rp <= '0;
            rq_cnt <= '0;
        end
        else
        begin
            tq_wp <= tq_wp + AW'(tq_push);
            tq_rp <= tq_rp + AW'(tx_go);
            tq_cnt <= tq_cnt + (AW+1)'(tq_push) - (AW+1)'(tx_go);
            rq_wp <= rq_wp + AW'(rq_push);
            rq_rp <= rq_rp + AW'(rq_pop);
            rq_cnt <= rq_cnt + (AW+1)'(rq_push) - (AW+1)'(rq_pop);
        end
    end

    //======================================================================
    // Transmitter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_st <= amf_pkg::TXS_IDLE;
            tx_bc <= 16'h1;
            tx_idx <= 10'h0;
            tx_nlow <= 10'h0;
            tx_total <= 10'h0;
            tx_sh <= 16'h0;
            tx_brk <= 1'b0;
            txd <= 1'b1;
        end
        else
        begin
            txd <= next_txd;
            case (tx_st)
                amf_pkg::TXS_IDLE:
                    if (tx_go)
                    begin
                        tx_st <= amf_pkg::TXS_RUN;
                        tx_bc <= bit_cyc;
                        tx_idx <= 10'h0;
                        tx_brk <= tq_head[9];
                        tx_sh <= 16'(amf_pkg::amf_frame(len, par, multidrop_bus_mode,
                            tq_head[8:0]));
                        tx_nlow <= go_low;
                        tx_total <= go_total;
                    end
                amf_pkg::TXS_RUN:
                begin
                    tx_bc <= tx_tick ? bit_cyc : tx_bc - 16'h1;
                    if (tx_tick)
                        tx_idx <= tx_idx + 10'h1;
                    if (tx_end)
                        tx_st <= amf_pkg::TXS_IDLE;
                end
                default:
                    tx_st <= amf_pkg::TXS_IDLE;
            endcase
        end
    end

    //======================================================================
    // Receiver and flow control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_q1 <= 1'b1;
            rx_q2 <= 1'b1;
            rx_q3 <= 1'b1;
            cts_q1 <= 1'b1;
            cts_q2 <= 1'b1;
            rx_st <= amf_pkg::RXS_IDLE;
            rx_bc <= 16'h1;
            rx_idx <= 4'h0;
            rx_sh <= 12'h0;
            rx_fin <= 1'b0;
            node_sel <= 1'b0;
            rts_n <= 1'b1;
        end
        else
        begin
            rx_q1 <= link.to_dev;
            rx_q2 <= rx_q1;
            rx_q3 <= rx_q2;
            cts_q1 <= link.cts_n;
            cts_q2 <= cts_q1;
            rx_fin <= rx_done;
            rts_n <= afc && (8'(rq_cnt) >= 8'(rts_lvl));
            if (rx_fin && multidrop_bus_mode && rx_word[8])
                node_sel <= rx_hit;
            case (rx_st)
                amf_pkg::RXS_IDLE:
                    if (rx_q3 && !rx_q2)
                    begin
                        rx_st <= amf_pkg::RXS_BITS;
                        rx_bc <= {1'b0, bit_cyc[15:1]} + 16'h1;
                        rx_idx <= 4'h0;
                    end
                amf_pkg::RXS_BITS:
                    if (rx_tick)
                    begin
                        rx_sh[rx_idx] <= rx_q2;
                        rx_idx <= rx_idx + 4'h1;
                        rx_bc <= bit_cyc;
                        // A start bit gone high by mid-cell was a glitch
                        if (rx_done || (rx_idx == 4'h0 && rx_q2))
                            rx_st <= amf_pkg::RXS_IDLE;
                    end
                    else
                        rx_bc <= rx_bc - 16'h1;
                default:
                    rx_st <= amf_pkg::RXS_IDLE;
            endcase
        end
    end
endmodule

// ==== logic/amf_pkg.sv ====
// Constants, types and frame helpers shared by both ends of the serial link
//==========================================================================
package amf_pkg;
    //======================================================================
    // Register map and fields
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DIV = 8'h04;
    localparam logic [7:0] OFF_CFG = 8'h08;
    localparam logic [7:0] OFF_TXD = 8'h0C;
    localparam logic [7:0] OFF_RXD = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam int CTRL_LEN = 0;
    localparam int CTRL_PAR = 2;
    localparam int CTRL_STOP = 4;
    localparam int CTRL_MDB = 6;
    localparam int CTRL_AFC = 7;
    localparam int CTRL_DTX = 8;
    localparam int CTRL_DRX = 9;
    localparam int CFG_GAP = 0;
    localparam int CFG_BRK = 8;
    localparam int CFG_RTS = 16;
    localparam int CFG_NODE = 24;
    localparam int TXD_BRK = 9;
    localparam int RXD_EMPTY = 31;
    localparam int ST_W = 5;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h2;
    //======================================================================
    // Reset values and timing
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_HZ = 115_200;
    localparam int BIT_CYC = CLK_HZ / BAUD_HZ;
    localparam logic [31:0] CTRL_RST = 32'h0000_0003;
    localparam logic [15:0] DIV_RST = 16'(BIT_CYC);
    localparam logic [31:0] CFG_RST = 32'h0003_0D00;

    typedef enum logic {TXS_IDLE, TXS_RUN} amf_tx_st_t;
    typedef enum logic {RXS_IDLE, RXS_BITS} amf_rx_st_t;

    //======================================================================
    // Frame helpers
    function automatic logic [7:0] amf_mask(input logic [1:0] len, input logic [7:0] d);
        return d & (8'hFF >> (2'h3 - len));
    endfunction

    function automatic logic amf_par(input logic [1:0] par, input logic [7:0] d);
        return (par == PAR_ODD) ^ (^d);
    endfunction

    // Start plus data plus optional parity and address bits
    function automatic logic [3:0] amf_nlow(input logic [1:0] len, par, input logic mdb);
        return 4'h6 + {2'h0, len} + {3'h0, par != PAR_NONE} + {3'h0, mdb};
    endfunction

    function automatic logic [10:0] amf_frame(input logic [1:0] len, par,
        input logic mdb, input logic [8:0] w);
        logic [7:0] d;
        logic [10:0] f;
        logic [3:0] p;
        d = amf_mask(len, w[7:0]);
        f = {2'h0, d, 1'b0};
        p = 4'h6 + {2'h0, len};
        if (par != PAR_NONE)
        begin
            f[p] = amf_par(par, d);
            p = p + 4'h1;
        end
        if (mdb)
            f[p] = w[8];
        return f;
    endfunction

    // Returns {framing error, parity error, address flag, data}
    function automatic logic [10:0] amf_unpack(input logic [1:0] len, par,
        input logic mdb, input logic [11:0] rb);
        logic [7:0] d;
        logic [3:0] p;
        logic pe;
        logic ad;
        d = amf_mask(len, rb[8:1]);
        p = 4'h6 + {2'h0, len};
        pe = 1'b0;
        ad = 1'b0;
        if (par != PAR_NONE)
        begin
            pe = rb[p] != amf_par(par, d);
            p = p + 4'h1;
        end
        if (mdb)
        begin
            ad = rb[p];
            p = p + 4'h1;
        end
        return {!rb[p], pe, ad, d};
    endfunction
endpackage

// ==== logic/amf_link_if.sv ====
// Serial link between the port and its remote partner
`timescale 1ns/1ps
interface amf_link_if;
    logic to_rem;
    logic to_dev;
    logic cts_n;
    logic rts_n;
    modport dev (output to_rem, output rts_n, input to_dev, input cts_n);
    modport rem (input to_rem, input rts_n, output to_dev, output cts_n);
endinterface

// ==== logic/amf_remote.sv ====
// Remote end: plain serial partner with matching frame settings
`timescale 1ns/1ps
module amf_remote #(
    parameter logic [15:0] BIT_CYC = amf_pkg::DIV_RST
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] cfg_len,
    input wire logic [1:0] cfg_par,
    input wire logic [1:0] cfg_stop,
    input wire logic cfg_mdb,
    input wire logic cfg_afc,
    input wire logic hold,
    input wire logic tx_valid,
    input wire logic [8:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [8:0] rx_data,
    output logic rx_perr,
    output logic rx_ferr,
    amf_link_if.rem link
);
    //======================================================================
    // State
    amf_pkg::amf_tx_st_t tx_st;
    amf_pkg::amf_rx_st_t rx_st;
    logic [15:0] tx_bc, rx_bc;
    logic [3:0] tx_idx, tx_total, tx_nlow, rx_idx;
    logic [15:0] tx_sh;
    logic [11:0] rx_sh;
    logic txd, cts_n, rx_q1, rx_q2, rx_q3, rts_q1, rts_q2, rx_fin;

    wire [3:0] nlow = amf_pkg::amf_nlow(cfg_len, cfg_par, cfg_mdb);
    wire tx_tick = tx_bc == 16'h1;
    wire tx_go = tx_valid && tx_ready;
    wire tx_end = tx_st == amf_pkg::TXS_RUN && tx_tick && tx_idx == tx_total - 4'h1;
    wire next_txd = !(tx_st == amf_pkg::TXS_RUN && tx_idx < tx_nlow) || tx_sh[tx_idx];
    wire [10:0] rx_word = amf_pkg::amf_unpack(cfg_len, cfg_par, cfg_mdb, rx_sh);
    wire rx_tick = rx_bc == 16'h1;
    wire rx_done = rx_st == amf_pkg::RXS_BITS && rx_tick && rx_idx == nlow;

    assign tx_ready = tx_st == amf_pkg::TXS_IDLE && (!cfg_afc || !rts_q2);
    assign link.to_dev = txd;
    assign link.cts_n = cts_n;

    //======================================================================
    // Transmitter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_st <= amf_pkg::TXS_IDLE;
            tx_bc <= 16'h1;
            tx_idx <= 4'h0;
            tx_total <= 4'h0;
            tx_nlow <= 4'h0;
            tx_sh <= 16'h0;
            txd <= 1'b1;
            cts_n <= 1'b1;
        end
        else
        begin
            txd <= next_txd;
            cts_n <= hold;
            case (tx_st)
                amf_pkg::TXS_IDLE:
                    if (tx_go)
                    begin
                        tx_st <= amf_pkg::TXS_RUN;
                        tx_bc <= BIT_CYC;
                        tx_idx <= 4'h0;
                        tx_nlow <= nlow;
                        tx_total <= nlow + {2'h0, cfg_stop} + 4'h1;
                        tx_sh <= 16'(amf_pkg::amf_frame(cfg_len, cfg_par, cfg_mdb, tx_data));
                    end
                amf_pkg::TXS_RUN:
                begin
                    tx_bc <= tx_tick ? BIT_CYC : tx_bc - 16'h1;
                    if (tx_tick)
                        tx_idx <= tx_idx + 4'h1;
                    if (tx_end)
                        tx_st <= amf_pkg::TXS_IDLE;
                end
                default:
                    tx_st <= amf_pkg::TXS_IDLE;
            endcase
        end
    end

    //======================================================================
    // Receiver
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_q1 <= 1'b1;
            rx_q2 <= 1'b1;
            rx_q3 <= 1'b1;
            rts_q1 <= 1'b1;
            rts_q2 <= 1'b1;
            rx_st <= amf_pkg::RXS_IDLE;
            rx_bc <= 16'h1;
            rx_idx <= 4'h0;
            rx_sh <= 12'h0;
            rx_fin <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 9'h0;
            rx_perr <= 1'b0;
            rx_ferr <= 1'b0;
        end
        else
        begin
            rx_q1 <= link.to_rem;
            rx_q2 <= rx_q1;
            rx_q3 <= rx_q2;
            rts_q1 <= link.rts_n;
            rts_q2 <= rts_q1;
            rx_fin <= rx_done;
            rx_valid <= rx_fin;
            if (rx_fin)
            begin
                rx_data <= rx_word[8:0];
                rx_perr <= rx_word[9];
                rx_ferr <= rx_word[10];
            end
            case (rx_st)
                amf_pkg::RXS_IDLE:
                    if (rx_q3 && !rx_q2)
                    begin
                        rx_st <= amf_pkg::RXS_BITS;
                        rx_bc <= {1'b0, BIT_CYC[15:1]} + 16'h1;
                        rx_idx <= 4'h0;
                    end
                amf_pkg::RXS_BITS:
                    if (rx_tick)
                    begin
                        rx_sh[rx_idx] <= rx_q2;
                        rx_idx <= rx_idx + 4'h1;
                        rx_bc <= BIT_CYC;
                        if (rx_done || (rx_idx == 4'h0 && rx_q2))
                            rx_st <= amf_pkg::RXS_IDLE;
                    end
                    else
                        rx_bc <= rx_bc - 16'h1;
                default:
                    rx_st <= amf_pkg::RXS_IDLE;
            endcase
        end
    end
endmodule

// ==== sim/amf_link_props.sv ====
// Checker of the serial link wires between both ends
`timescale 1ns/1ps
module amf_link_props #(
    parameter int BIT = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic to_rem,
    input wire logic to_dev,
    input wire logic cts_n,
    input wire logic rts_n
);
    //======================================================================
    // Low run length of the device line
    logic [11:0] lo_t;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            lo_t <= 12'h000;
        else
            lo_t <= to_rem ? 12'h000 : lo_t + 12'h001;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Repetition counts fixed to a 4-cycle bit cell
    sequence s_low(x);
        !x[*4];
    endsequence
    sequence s_high(x);
        x[*4];
    endsequence
    //======================================================================
    // Assertions
    property p_idle_rst;
        disable iff (1'h0) !presetn |-> to_rem && to_dev;
    endproperty
    a_idle_rst: assert property (p_idle_rst) else $error("line busy in reset");
    property p_flow_rst;
        disable iff (1'h0) !presetn |-> rts_n && cts_n;
    endproperty
    a_flow_rst: assert property (p_flow_rst) else $error("flow pin low in reset");
    property p_start_t;
        $fell(to_rem) |-> s_low(to_rem);
    endproperty
    a_start_t: assert property (p_start_t) else $error("device start cell short");
    property p_stop_t;
        $rose(to_rem) |-> s_high(to_rem);
    endproperty
    a_stop_t: assert property (p_stop_t) else $error("device high cell short");
    property p_cell_t;
        $rose(to_rem) |-> (32'(lo_t) % BIT) == 0;
    endproperty
    a_cell_t: assert property (p_cell_t) else $error("device low run not whole cells");
    property p_start_r;
        $fell(to_dev) |-> s_low(to_dev);
    endproperty
    a_start_r: assert property (p_start_r) else $error("remote start cell short");
    property p_stop_r;
        $rose(to_dev) |-> s_high(to_dev);
    endproperty
    a_stop_r: assert property (p_stop_r) else $error("remote high cell short");
    property p_frame_r;
        $fell(to_dev) |-> ##[1:44] to_dev;
    endproperty
    a_frame_r: assert property (p_frame_r) else $error("remote frame lacks stop");
endmodule

// ==== sim/async_serial_port_mdb_flow_tb.sv ====
// Bench for both ends of the serial link
`timescale 1ns/1ps
module async_serial_port_mdb_flow_tb;
    typedef struct packed {logic [1:0] len, par, stop; logic [7:0] d, e;} amf_row_t;
    logic pclk = 1'h0, presetn = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, irq, dtx, drx, tr, rv, rpe, rfe, rerr, lv;
    logic [1:0] c_len = 2'h3, c_par = 2'h0, c_stop = 2'h0;
    logic c_mdb = 1'h0, c_afc = 1'h0, hold = 1'h0, tv = 1'h0;
    logic [8:0] td = 9'h000, rd;
    logic [6:0] wv;
    int failures = 0, cmp_count = 0;
    int runs [11];
    amf_row_t rows [3];
    amf_link_if link();
    amf_port #(.DEPTH(4)) amf_port_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .dma_tx_req(dtx), .dma_rx_req(drx),
        .link(link));
    amf_remote #(.BIT_CYC(16'h0004)) amf_remote_i (.pclk(pclk), .presetn(presetn),
        .cfg_len(c_len), .cfg_par(c_par), .cfg_stop(c_stop), .cfg_mdb(c_mdb),
        .cfg_afc(c_afc), .hold(hold), .tx_valid(tv), .tx_data(td), .tx_ready(tr),
        .rx_valid(rv), .rx_data(rd), .rx_perr(rpe), .rx_ferr(rfe), .link(link));
    amf_link_props #(.BIT(4)) amf_link_props_i (.pclk(pclk), .presetn(presetn),
        .to_rem(link.to_rem), .to_dev(link.to_dev), .cts_n(link.cts_n), .rts_n(link.rts_n));
    assign wv = {pready, irq, link.rts_n, drx, rv, tr, link.to_rem};
    always #20 pclk = ~pclk;
    //======================================================================
    // Tasks
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bounded wait; running out counts as a mismatch
    task automatic wait_for(input int k, input logic v);
        int n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (wv[k] !== v && n < 3000);
        if (wv[k] !== v)
        begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end
    endtask
    // Idle edge first, so psel is never driven twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        wait_for(6, 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rsend(input logic [8:0] w);
        tv <= 1'h1;
        td <= w;
        wait_for(1, 1'h1);
        tv <= 1'h0;
    endtask
    //======================================================================
    // Sequence
    initial
    begin
        // A real falling edge, so the asynchronous reset branches run
        presetn <= 1'h0;
        rows[0] = '{2'h0, 2'h1, 2'h0, 8'h35, 8'h15};
        rows[1] = '{2'h1, 2'h2, 2'h1, 8'hEA, 8'h2A};
        rows[2] = '{2'h2, 2'h0, 2'h3, 8'hFF, 8'h7F};
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 8'h00, 32'h0);
        chk(rdat, 32'h0000_0003);
        apb(1'h0, 8'h1C, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'h1, 8'h04, 32'h0000_0004);
        foreach (rows[i])
        begin
            c_len <= rows[i].len;
            c_par <= rows[i].par;
            c_stop <= rows[i].stop;
            apb(1'h1, 8'h00, {22'h0, 2'h3, 2'h0, rows[i].stop, rows[i].par, rows[i].len});
            rsend({1'h0, rows[i].d});
            apb(1'h1, 8'h0C, {24'h0, rows[i].d});
            chk({31'h0, dtx}, 32'h1);
            wait_for(2, 1'h1);
            chk({21'h0, rpe, rfe, rd}, {24'h0, rows[i].e});
            wait_for(3, 1'h1);
            apb(1'h0, 8'h10, 32'h0);
            chk(rdat, {24'h0, rows[i].e});
        end
        // Frame, gap and break queued back to back
        c_len <= 2'h3;
        c_par <= 2'h0;
        c_stop <= 2'h0;
        apb(1'h1, 8'h00, 32'h0000_0003);
        apb(1'h1, 8'h08, 32'h0003_0302);
        fork
        begin
            apb(1'h1, 8'h0C, 32'h0000_0055);
            apb(1'h1, 8'h0C, 32'h0000_0200);
        end
        begin
            wait_for(0, 1'h0);
            for (int k = 0; k < 11; k++)
            begin
                lv = link.to_rem;
                runs[k] = 0;
                while (link.to_rem === lv && runs[k] < 900)
                begin
                    @(posedge pclk);
                    runs[k]++;
                end
            end
        end
        join
        for (int k = 0; k < 9; k++)
            chk(32'(runs[k]), 32'h4);
        // Stop and gap cells plus the one idle cycle between frames
        chk(32'(runs[9]), 32'hD);
        chk(32'(runs[10]), 32'hC);
        // Paused by the remote, then released
        hold <= 1'h1;
        apb(1'h1, 8'h00, 32'h0000_0083);
        apb(1'h1, 8'h0C, 32'h0000_000F);
        repeat (40) @(posedge pclk);
        chk({31'h0, link.to_rem}, 32'h1);
        chk({31'h0, link.rts_n}, 32'h0);
        hold <= 1'h0;
        wait_for(0, 1'h0);
        wait_for(2, 1'h1);
        chk({23'h0, rd}, 32'h0000_000F);
        // Multidrop filter and interrupt
        c_mdb <= 1'h1;
        apb(1'h1, 8'h00, 32'h0000_0243);
        apb(1'h1, 8'h08, 32'h5A00_0300);
        apb(1'h1, 8'h14, 32'h0000_001F);
        apb(1'h1, 8'h18, 32'h0000_0001);
        rsend(9'h133);
        rsend(9'h011);
        repeat (80) @(posedge pclk);
        chk({30'h0, irq, drx}, 32'h0);
        rsend(9'h15A);
        wait_for(5, 1'h1);
        apb(1'h0, 8'h10, 32'h0);
        chk(rdat, 32'h0000_015A);
        apb(1'h1, 8'h14, 32'h0000_0001);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        report_and_stop();
    end
endmodule
